//--- rcv_pkg.sv
// Shared constants for the resolver converter register bank.
// Assumes a 20 MHz system clock and a 32-bit SPI frame.
package rcv_pkg;
  localparam int NREG = 27;
  localparam logic [4:0] IDX_TLOOP = 5'h06;
  localparam logic [4:0] IDX_LAST_DIAG = 5'h0B;
  localparam logic [4:0] IDX_CTRL_A = 5'h0A;
  localparam logic [4:0] IDX_CTRL_B = 5'h0B;
  localparam logic [4:0] IDX_RUNTIME = 5'h0C;
  localparam logic [4:0] IDX_STAT1 = 5'h0D;
  localparam logic [4:0] IDX_STAT2 = 5'h0E;
  localparam logic [4:0] IDX_STAT3 = 5'h0F;
  localparam logic [4:0] IDX_STAT4 = 5'h10;
  localparam logic [4:0] IDX_ANGLE = 5'h11;
  localparam logic [4:0] IDX_VEL = 5'h12;
  localparam logic [4:0] IDX_STAT7 = 5'h13;
  localparam logic [4:0] IDX_CKS_LIVE = 5'h14;
  localparam logic [4:0] IDX_CKS_STORED = 5'h15;
  localparam logic [4:0] IDX_CKS_CALC = 5'h16;
  localparam logic [4:0] IDX_NV_CTRL_A = 5'h17;
  localparam logic [4:0] IDX_CKS_CTRL = 5'h18;
  localparam logic [4:0] IDX_NV_KEY = 5'h19;
  localparam logic [4:0] IDX_DEV_KEY = 5'h1A;
  localparam logic [7:0] RD_CODE [NREG] = '{
    8'h53, 8'h6B, 8'h65, 8'hEC, 8'h52, 8'hE9, 8'hA6, 8'hC2, 8'h57,
    8'hA6, 8'h90, 8'h63, 8'hDD, 8'h81, 8'h4D, 8'h84, 8'h1F, 8'h41,
    8'h6F, 8'h81, 8'h4F, 8'h0F, 8'hD9, 8'hE3, 8'h7A, 8'hBA, 8'h64};
  localparam logic [7:0] WR_CODE [NREG] = '{
    8'h87, 8'h26, 8'h17, 8'h39, 8'h75, 8'h83, 8'h42, 8'h91, 8'h85,
    8'h42, 8'h91, 8'h38, 8'hAE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hFC, 8'hE7, 8'h00, 8'h6E, 8'h66, 8'h56, 8'h95};
  localparam logic [NREG-1:0] HAS_WR = 27'h7B01FFF;
  localparam logic [15:0] RST_VAL [NREG] = '{
    16'hBFC0, 16'h00C0, 16'hFCFF, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [1:0] STAT_ADDR_NF = 2'h3;
  localparam int STAT_CRC_ERR_BIT = 2;
  localparam int DIAG_REQ_BIT = 2;
  localparam int DIAG_LEAVE_BIT = 0;
  localparam int VEL_MODE12_BIT = 0;
  localparam int CKS_LATCH_BIT = 0;
  localparam logic [15:0] KEY_SEQ [4] = '{
    16'h000F, 16'h0055, 16'h00AA, 16'h00F0};
  localparam logic [4:0] KEY_IDX [2] = '{IDX_DEV_KEY, IDX_NV_KEY};
  localparam int CLK_HZ = 20_000_000;
  localparam int UNLOCK_WINDOW_MS = 10;
  localparam int UNLOCK_WINDOW_CYC = UNLOCK_WINDOW_MS * (CLK_HZ / 1000);
  localparam int AUTO_EXIT_CYC = 16;
  localparam logic [5:0] CRC_POLY = 6'h1B;
  localparam logic [5:0] CRC_SEED = 6'h3F;
  typedef enum logic [1:0] {
    ST_DIAG   = 2'b01,
    ST_NORMAL = 2'b10
  } rcv_state_t;
endpackage

//--- rcv_frame_if.sv
// Frame carrier between the SPI link logic and the register core.
// Words are held stable by their writer; only done_tgl crosses.
`timescale 1ns/1ns
`default_nettype none
interface rcv_frame_if;
  logic [31:0] rx_word;
  logic        done_tgl;
  logic [31:0] tx_word;
  modport link (output rx_word, output done_tgl, input tx_word);
  modport core (input rx_word, input done_tgl, output tx_word);
endinterface
`default_nettype wire

//--- rcv_spi_link.sv
// SPI shifter on the link clock, mode 1: MISO moves on rising sclk,
// MOSI is taken on falling sclk. Assumes tx_word is stable in frames.
`timescale 1ns/1ns
`default_nettype none
module rcv_spi_link
  import rcv_pkg::*;
(
  input  wire logic   rst_n,
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   mosi,
  output var  logic   miso,
  output var  logic   miso_oe_n,
  rcv_frame_if.link   frm
);
  logic [4:0]  bit_cnt_r;
  logic [30:0] shift_r;

  // Clock stops between frames, so chip select clears the count
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  always_ff @(negedge sclk) begin
    shift_r <= {shift_r[29:0], mosi};
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      frm.rx_word  <= 32'h0000_0000;
      frm.done_tgl <= 1'b0;
    end else if (!cs_n && bit_cnt_r == 5'h1F) begin
      frm.rx_word  <= {shift_r, mosi};
      frm.done_tgl <= ~frm.done_tgl;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso      <= frm.tx_word[5'h1F - bit_cnt_r];
      miso_oe_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rcv_reg_bank.sv
// Register bank of a resolver-to-digital converter behind a SPI link.
// Assumes status and result words come from logic on the same clock.
//
// Functional notes
// - Velocity is signed, 10 or 12 bits wide
// - Bit 11 holds the velocity sign
// - Angle drives a 10-bit DAC code
// - Some locations share read or write codes
// - Normal state refuses diag writes, status 0b11
// - Diag-only registers readable in every state
// - Control A and B need device unlock
// - Nonvolatile control A needs nonvolatile unlock
// - Read answer arrives in the next frame
// - Six-bit CRC over upper 24 frame bits
// - SPI diag request holds diag until leave
// - Four key writes in diag state within 10 ms unlock
`timescale 1ns/1ns
`default_nettype none
module rcv_reg_bank
  import rcv_pkg::*;
#(
  parameter int UNLOCK_CYC = UNLOCK_WINDOW_CYC,
  parameter int AUTO_CYC   = AUTO_EXIT_CYC
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output var  logic        miso,
  output var  logic        miso_oe_n,
  input  wire logic [11:0] angle_word,
  input  wire logic [11:0] velocity_word,
  input  wire logic [15:0] fault_in_1,
  input  wire logic [15:0] fault_in_2,
  input  wire logic [15:0] fault_in_3,
  input  wire logic [15:0] fault_in_4,
  input  wire logic [15:0] fault_in_7,
  output var  logic [9:0]  analog_angle_code,
  output var  logic        diag_state,
  output var  logic        dev_unlocked,
  output var  logic        nv_unlocked
);
  localparam int WIN_W = $clog2(UNLOCK_CYC + 1);
  localparam int AUTO_W = $clog2(AUTO_CYC + 1);

  rcv_frame_if frm ();

  rcv_spi_link u_link (
    .rst_n     (rst_n),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .miso      (miso),
    .miso_oe_n (miso_oe_n),
    .frm       (frm.link)
  );

  function automatic logic [5:0] f_crc6(input logic [23:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      fb = c[5] ^ d[i];
      c  = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  logic             tgl_s1_r;
  logic             tgl_s2_r;
  logic             tgl_s3_r;
  logic             new_frame;
  logic [7:0]       cmd;
  logic [15:0]      wdata;
  logic             crc_ok;
  logic             rd_hit;
  logic             wr_hit;
  logic [4:0]       rd_idx;
  logic [4:0]       wr_idx;
  logic             rd_cmd;
  logic             wr_cmd;
  logic             wr_ro;
  logic             wr_refused;
  logic             rd_refused;
  logic             do_write;
  logic [15:0]      rd_val;
  logic [15:0]      reg_r [NREG];
  rcv_state_t       state_r;
  logic             diag_held_r;
  logic [AUTO_W-1:0] auto_cnt_r;
  logic [1:0]       stat_r;
  logic             crc_err_r;
  logic [15:0]      angle_r;
  logic [15:0]      vel_r;
  logic [15:0]      cks_stored_r;
  logic [15:0]      cks_live;
  logic [7:0]       rsp_cmd_r;
  logic [15:0]      rsp_data_r;
  logic [1:0]       unl_r;
  logic             mode12;

  // Frame-done toggle crossing; data words stay still until next frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= frm.done_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign new_frame = tgl_s2_r ^ tgl_s3_r;
  assign cmd       = frm.rx_word[31:24];
  assign wdata     = frm.rx_word[23:8];
  assign crc_ok    = f_crc6(frm.rx_word[31:8]) == frm.rx_word[5:0];
  assign mode12    = reg_r[IDX_TLOOP][VEL_MODE12_BIT];

  // Shared codes go to the lowest location, but control A keeps its own
  always_comb begin
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    rd_idx = 5'h00;
    wr_idx = 5'h00;
    for (int i = NREG - 1; i >= 0; i--) begin
      if (cmd == RD_CODE[i]) begin
        rd_hit = 1'b1;
        rd_idx = 5'(i);
      end
      if (HAS_WR[i] && cmd == WR_CODE[i] &&
          !(wr_hit && wr_idx == IDX_CTRL_A)) begin
        wr_hit = 1'b1;
        wr_idx = 5'(i);
      end
    end
  end

  assign rd_cmd = new_frame && crc_ok && rd_hit;
  assign wr_cmd = new_frame && crc_ok && wr_hit && !rd_hit;
  assign wr_ro  = wr_idx >= IDX_STAT1 && wr_idx <= IDX_CKS_CALC;

  always_comb begin
    wr_refused = 1'b0;
    if (wr_idx <= IDX_LAST_DIAG && state_r != ST_DIAG) begin
      wr_refused = 1'b1;
    end
    if ((wr_idx == IDX_CTRL_A || wr_idx == IDX_CTRL_B) && !unl_r[0]) begin
      wr_refused = 1'b1;
    end
    if (wr_idx == IDX_NV_CTRL_A && !unl_r[1]) begin
      wr_refused = 1'b1;
    end
  end

  always_comb begin
    rd_refused = 1'b0;
    if ((rd_idx == IDX_CTRL_A || rd_idx == IDX_CTRL_B) && !unl_r[0]) begin
      rd_refused = 1'b1;
    end
    if (rd_idx == IDX_NV_CTRL_A && !unl_r[1]) begin
      rd_refused = 1'b1;
    end
  end

  assign do_write = wr_cmd && !wr_refused && !wr_ro;

  always_comb begin
    cks_live = 16'h0000;
    for (int i = 0; i <= int'(IDX_LAST_DIAG); i++) begin
      cks_live = cks_live ^ reg_r[i];
    end
  end

  // Diag-only locations are read from the same store in any state
  always_comb begin
    unique case (rd_idx)
      IDX_STAT1:      rd_val = {fault_in_1[15:3], crc_err_r, stat_r};
      IDX_STAT2:      rd_val = fault_in_2;
      IDX_STAT3:      rd_val = fault_in_3;
      IDX_STAT4:      rd_val = fault_in_4;
      IDX_ANGLE:      rd_val = angle_r;
      IDX_VEL:        rd_val = vel_r;
      IDX_STAT7:      rd_val = fault_in_7;
      IDX_CKS_LIVE:   rd_val = cks_live;
      IDX_CKS_STORED: rd_val = cks_stored_r;
      IDX_CKS_CALC:   rd_val = cks_live;
      default:        rd_val = reg_r[rd_idx];
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        reg_r[i] <= RST_VAL[i];
      end
    end else if (do_write) begin
      reg_r[wr_idx] <= wdata;
      if (wr_idx == IDX_CTRL_A) begin
        // Leave request acts once and does not stay stored
        reg_r[wr_idx][DIAG_LEAVE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cks_stored_r <= 16'h0000;
    end else if (do_write && wr_idx == IDX_CKS_CTRL &&
                 wdata[CKS_LATCH_BIT]) begin
      cks_stored_r <= cks_live;
    end
  end

  // Operating state: automatic exit after reset unless SPI asked or fault_in_1 is nonzero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r     <= ST_DIAG;
      diag_held_r <= 1'b0;
      auto_cnt_r  <= '0;
    end else begin
      if (auto_cnt_r != AUTO_W'(AUTO_CYC)) begin
        auto_cnt_r <= auto_cnt_r + AUTO_W'(1);
      end
      unique case (state_r)
        ST_DIAG: begin
          if (do_write && wr_idx == IDX_CTRL_A &&
              wdata[DIAG_LEAVE_BIT]) begin
            state_r     <= ST_NORMAL;
            diag_held_r <= 1'b0;
          end else if (do_write && wr_idx == IDX_RUNTIME &&
                       wdata[DIAG_REQ_BIT]) begin
            diag_held_r <= 1'b1;
          end else if (!diag_held_r && fault_in_1 == 16'h0000 &&
                       auto_cnt_r == AUTO_W'(AUTO_CYC - 1)) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (do_write && wr_idx == IDX_RUNTIME &&
              wdata[DIAG_REQ_BIT]) begin
            state_r     <= ST_DIAG;
            diag_held_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // Unlock sequencers: device keys and nonvolatile keys
  for (genvar k = 0; k < 2; k++) begin : g_unlock
    logic [1:0]       step_r;
    logic [WIN_W-1:0] win_r;
    logic             key_wr;

    assign key_wr = do_write && wr_idx == KEY_IDX[k];

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        step_r   <= 2'h0;
        win_r    <= '0;
        unl_r[k] <= 1'b0;
      end else if (unl_r[k]) begin
        step_r <= 2'h0;
      end else if (key_wr && state_r == ST_DIAG) begin
        if (wdata == KEY_SEQ[step_r]) begin
          if (step_r == 2'h3) begin
            unl_r[k] <= 1'b1;
            step_r   <= 2'h0;
          end else begin
            step_r <= step_r + 2'h1;
          end
          if (step_r == 2'h0) begin
            win_r <= '0;
          end else begin
            win_r <= win_r + WIN_W'(1);
          end
        end else begin
          step_r <= 2'h0;
        end
      end else if (step_r != 2'h0) begin
        if (win_r >= WIN_W'(UNLOCK_CYC - 1)) begin
          step_r <= 2'h0;
        end else begin
          win_r <= win_r + WIN_W'(1);
        end
      end
    end
  end

  // Refusal and CRC flags; a new event wins over the clearing read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_r    <= 2'h0;
      crc_err_r <= 1'b0;
    end else begin
      if (rd_cmd && rd_idx == IDX_STAT1) begin
        stat_r    <= 2'h0;
        crc_err_r <= 1'b0;
      end
      if (wr_cmd && wr_refused) begin
        stat_r <= STAT_ADDR_NF;
      end
      if (rd_cmd && rd_refused) begin
        stat_r <= STAT_ADDR_NF;
      end
      if (new_frame && !crc_ok) begin
        crc_err_r <= 1'b1;
      end
    end
  end

  // Results sampled each cycle from the tracking logic
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      angle_r <= 16'h0000;
      vel_r   <= 16'h0000;
    end else begin
      angle_r <= mode12 ? {4'h0, angle_word} : {6'h00, angle_word[9:0]};
      if (mode12) begin
        vel_r <= {{4{velocity_word[11]}}, velocity_word};
      end else begin
        vel_r <= {{6{velocity_word[9]}}, velocity_word[9:0]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      analog_angle_code <= 10'h000;
    end else if (mode12) begin
      analog_angle_code <= angle_word[11:2];
    end else begin
      analog_angle_code <= angle_word[9:0];
    end
  end

  // Answer for the next frame; a bad frame leaves the answer as it was
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_cmd_r  <= 8'h00;
      rsp_data_r <= 16'h0000;
    end else if (new_frame && crc_ok) begin
      rsp_cmd_r <= cmd;
      if (rd_cmd) begin
        rsp_data_r <= rd_refused ? 16'h0000 : rd_val;
      end else begin
        rsp_data_r <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frm.tx_word <= {16'h0000, 8'h00, 2'h0, f_crc6(24'h000000)};
    end else begin
      frm.tx_word <= {rsp_cmd_r, rsp_data_r, 2'h0,
                      f_crc6({rsp_cmd_r, rsp_data_r})};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      diag_state   <= 1'b1;
      dev_unlocked <= 1'b0;
      nv_unlocked  <= 1'b0;
    end else begin
      diag_state   <= state_r == ST_DIAG;
      dev_unlocked <= unl_r[0];
      nv_unlocked  <= unl_r[1];
    end
  end
endmodule
`default_nettype wire

//--- rcv_host_model.sv
// Host SPI controller model for the register bank, mode 1.
// Assumes one caller at a time; sclk rests low between frames.
`timescale 1ns/1ns
`default_nettype none
module rcv_host_model
  import rcv_pkg::*;
(
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  function automatic logic [5:0] crc6(input logic [23:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  // A set bad flips one CRC bit so the frame must be refused
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat,
                      input logic bad, output logic [31:0] rsp);
    logic [31:0] w;
    w = {cmd, dat, 2'b00, crc6({cmd, dat}) ^ {5'h00, bad}};
    #13 cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      #32 sclk = 1'b1;
      mosi = w[i];
      #32 sclk = 1'b0;
      rsp[i] = miso;
    end
    #32 cs_n = 1'b1;
    // Released line shows the inverse so no stale bit is trusted
    mosi = ~mosi;
    #400;
  endtask
endmodule
`default_nettype wire

//--- rcv_reg_bank_properties.sv
// Port-level checks for the register bank.
// Assumes a bind to rcv_reg_bank; all checks on the system clock.
`timescale 1ns/1ns
`default_nettype none
module rcv_reg_bank_properties (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        miso,
  input wire logic        miso_oe_n,
  input wire logic [11:0] angle_word,
  input wire logic [9:0]  analog_angle_code,
  input wire logic        diag_state,
  input wire logic        dev_unlocked,
  input wire logic        nv_unlocked
);
  logic [11:0] ang_r;
  always_ff @(posedge clock) begin
    ang_r <= angle_word;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_dac_code: assert property (
    $past(rst_n) |-> analog_angle_code == ang_r[11:2] ||
    analog_angle_code == ang_r[9:0])
    else $error("DAC code does not follow the angle");
  a_dev_sticky: assert property (
    $past(rst_n) && $past(dev_unlocked) |-> dev_unlocked)
    else $error("Device unlock lost");
  a_nv_sticky: assert property (
    $past(rst_n) && $past(nv_unlocked) |-> nv_unlocked)
    else $error("Nonvolatile unlock lost");
  a_dev_in_diag: assert property (
    $rose(dev_unlocked) |-> diag_state)
    else $error("Device unlock outside diagnostics");
  a_nv_in_diag: assert property (
    $rose(nv_unlocked) |-> diag_state)
    else $error("Nonvolatile unlock outside diagnostics");
  a_diag_hold: assert property (
    $rose(rst_n) |-> diag_state [*8])
    else $error("Diagnostics left too early after reset");
  a_reset_clear: assert property (
    $rose(rst_n) |-> !dev_unlocked && !nv_unlocked &&
    analog_angle_code == 10'h000)
    else $error("Unlock or DAC code survived reset");
  a_link_idle: assert property (
    $past(cs_n) && cs_n |-> miso_oe_n && !miso)
    else $error("Data line driven outside a frame");
endmodule
`default_nettype wire

//--- rcv_reg_bank_tb.sv
// Self-checking bench for the register bank driven by the host model.
// Assumes the host model paces frames and keeps the gap between them.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end end
module rcv_reg_bank_tb;
  import rcv_pkg::*;
  typedef struct packed {
    logic [11:0] vel;
    logic [11:0] ang;
    logic [15:0] vreg;
    logic [15:0] mag;
    logic [9:0]  dac;
  } rcv_row_t;
  rcv_row_t    rows [4] = '{
    '{12'h7FF, 12'hABC, 16'h07FF, 16'h07FF, 10'h2AF},
    '{12'h800, 12'h000, 16'hF800, 16'h0000, 10'h000},
    '{12'hFFF, 12'hFFF, 16'hFFFF, 16'h0001, 10'h3FF},
    '{12'h001, 12'h004, 16'h0001, 16'h0001, 10'h001}};
  logic        clock, rst_n, sclk, cs_n, mosi, miso, miso_oe_n;
  logic [11:0] angle_word, velocity_word;
  logic [15:0] fault_in_1, fault_in_2, fault_in_3, v, m;
  logic [15:0] fault_in_4, fault_in_7;
  logic [9:0]  analog_angle_code;
  logic        diag_state, dev_unlocked, nv_unlocked;
  logic [31:0] rsp;
  int          n_mismatch = 0;
  int          comparisons = 0;

  rcv_reg_bank #(.UNLOCK_CYC(400), .AUTO_CYC(16)) u_dut (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .angle_word(angle_word), .velocity_word(velocity_word),
    .fault_in_1(fault_in_1), .fault_in_2(fault_in_2),
    .fault_in_3(fault_in_3), .fault_in_4(fault_in_4),
    .fault_in_7(fault_in_7),
    .analog_angle_code(analog_angle_code), .diag_state(diag_state),
    .dev_unlocked(dev_unlocked), .nv_unlocked(nv_unlocked));
  rcv_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic frame(input logic [7:0] c, input logic [15:0] d,
                       input logic bad);
    u_host.xfer(c, d, bad, rsp);
    `CHK(rsp[5:0], u_host.crc6(rsp[31:8]))
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    frame(WR_CODE[i], d, 1'b0);
  endtask
  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    frame(RD_CODE[i], 16'h0000, 1'b0);
    frame(RD_CODE[i], 16'h0000, 1'b0);
    `CHK(rsp[31:24], RD_CODE[i])
    `CHK(rsp[23:8], e)
  endtask
  // The gap after the first key lets a timeout be provoked
  task automatic unlock(input int k, input int gap);
    for (int j = 0; j < 4; j++) begin
      wr(KEY_IDX[k], KEY_SEQ[j]);
      if (j == 0) repeat (gap) @(posedge clock);
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    angle_word = 12'h000;
    velocity_word = 12'h000;
    // A live fault keeps diagnostics until the request is written
    fault_in_1 = 16'h0008;
    fault_in_2 = 16'h1234;
    fault_in_3 = 16'h5678;
    fault_in_4 = 16'h9ABC;
    fault_in_7 = 16'hDEF0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    wr(IDX_RUNTIME, 16'h0004);
    @(negedge clock);
    fault_in_1 = 16'h0000;
    wr(IDX_TLOOP, 16'h0001);
    wr(5'h01, 16'h5A5A);
    foreach (rows[n]) begin
      @(negedge clock);
      velocity_word = rows[n].vel;
      angle_word = rows[n].ang;
      repeat (2) @(negedge clock);
      `CHK(analog_angle_code, rows[n].dac)
      rd(IDX_ANGLE, {4'h0, rows[n].ang});
      rd(IDX_VEL, rows[n].vreg);
      v = rsp[23:8];
      m = v[11] ? ((~v) + 16'h0001) & 16'h07FF : v & 16'h07FF;
      `CHK(m, rows[n].mag)
    end
    rd(IDX_CTRL_B, 16'h0000);
    rd(IDX_STAT1, 16'h0003);
    `CHK(diag_state, 1'b1)
    unlock(0, 500);
    `CHK(dev_unlocked, 1'b0)
    unlock(0, 0);
    `CHK(dev_unlocked, 1'b1)
    wr(IDX_CTRL_B, 16'h1234);
    rd(IDX_CTRL_B, 16'h1234);
    wr(IDX_NV_CTRL_A, 16'h00A5);
    rd(IDX_STAT1, 16'h0003);
    unlock(1, 0);
    wr(IDX_NV_CTRL_A, 16'h00A5);
    rd(IDX_NV_CTRL_A, 16'h00A5);
    wr(IDX_CKS_STORED, 16'hFFFF);
    rd(IDX_CKS_STORED, 16'h0000);
    wr(IDX_CTRL_A, 16'h0001);
    repeat (4) @(negedge clock);
    `CHK(diag_state, 1'b0)
    wr(5'h00, 16'h1111);
    rd(IDX_STAT1, 16'h0003);
    rd(5'h00, RST_VAL[0]);
    rd(5'h01, 16'h5A5A);
    rd(IDX_STAT2, 16'h1234);
    rd(IDX_STAT3, 16'h5678);
    rd(IDX_STAT4, 16'h9ABC);
    frame(WR_CODE[1], 16'h0000, 1'b1);
    rd(5'h01, 16'h5A5A);
    rd(IDX_STAT1, 16'h0004);
    @(negedge clock);
    // Reset leaves 10-bit resolution, so these words take the short path
    angle_word = 12'hABC;
    velocity_word = 12'h200;
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(dev_unlocked, 1'b0)
    `CHK(diag_state, 1'b1)
    `CHK(analog_angle_code, 10'h2BC)
    rd(5'h02, RST_VAL[2]);
    rd(IDX_ANGLE, 16'h02BC);
    rd(IDX_VEL, 16'hFE00);
    final_report();
  end
endmodule
bind rcv_reg_bank rcv_reg_bank_properties u_props (
  .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .miso(miso),
  .miso_oe_n(miso_oe_n), .angle_word(angle_word),
  .analog_angle_code(analog_angle_code), .diag_state(diag_state),
  .dev_unlocked(dev_unlocked), .nv_unlocked(nv_unlocked));
`default_nettype wire
